/* File: nvm_ctrl_pkg.sv */
package nvm_ctrl_pkg;

   // Register byte offsets on the AXI4-Lite slave
   localparam logic [4:0] OFS_CONTROL   = 5'h00;
   localparam logic [4:0] OFS_UNLOCK    = 5'h04;
   localparam logic [4:0] OFS_ADDR_LOW  = 5'h08;
   localparam logic [4:0] OFS_ADDR_HIGH = 5'h0C;
   localparam logic [4:0] OFS_DATA_LOW  = 5'h10;
   localparam logic [4:0] OFS_DATA_HIGH = 5'h14;
   localparam logic [4:0] OFS_STATUS    = 5'h18;

   // Control register field positions
   localparam int CTL_READ_START   = 0;
   localparam int CTL_WRITE_START  = 1;
   localparam int CTL_WRITE_ENABLE = 2;
   localparam int CTL_ROW_ERASE    = 3;
   localparam int CTL_LATCH_ONLY   = 4;
   localparam int CTL_CONFIG_SPACE = 6;

   // Status register field positions
   localparam int STS_DONE_FLAG  = 0;
   localparam int STS_IRQ_ENABLE = 1;
   localparam int STS_BUSY       = 2;

   // Unlock keys
   localparam logic [7:0] UNLOCK_KEY_FIRST  = 8'h55;
   localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

   // Address map windows
   localparam logic [15:0] PFM_BASE = 16'h8000;
   localparam logic [15:0] PFM_LAST = 16'h87FF;
   localparam logic [15:0] UID_BASE = 16'h8000;
   localparam logic [15:0] UID_LAST = 16'h8003;
   localparam logic [15:0] RO_BASE  = 16'h8005;
   localparam logic [15:0] RO_LAST  = 16'h800B;
   localparam logic [15:0] EE_BASE  = 16'hF000;
   localparam logic [15:0] EE_LAST  = 16'hF0FF;

   // Reset value and response codes
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;

   typedef enum logic [3:0] {
      SEQ_IDLE       = 4'b0001,
      SEQ_READ       = 4'b0010,
      SEQ_FOREGROUND = 4'b0100,
      SEQ_BACKGROUND = 4'b1000
   } seqState_t;

   typedef enum logic [2:0] {
      UL_IDLE = 3'b001,
      UL_KEY1 = 3'b010,
      UL_KEY2 = 3'b100
   } unlockState_t;

   typedef enum logic [2:0] {
      MEM_NONE      = 3'h0,
      MEM_READ      = 3'h1,
      MEM_LATCH     = 3'h2,
      MEM_ROW_WRITE = 3'h3,
      MEM_ROW_ERASE = 3'h4,
      MEM_EE_WRITE  = 3'h5
   } memOp_t;

   typedef enum logic [2:0] {
      CLS_NONE = 3'h0,
      CLS_PFM  = 3'h1,
      CLS_UID  = 3'h2,
      CLS_EE   = 3'h3,
      CLS_RO   = 3'h4
   } addrClass_t;

   typedef struct packed {
      logic        valid;
      memOp_t      op;
      logic        region;
      logic [15:0] addr;
      logic [13:0] data;
   } memCmd_t;

endpackage : nvm_ctrl_pkg

/* File: nvm_unlock_erase_write_ctrl.sv */
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps

module nvm_unlock_erase_write_ctrl #(
   parameter int ADDR_W = 5
) (
   input  wire logic                 core_clk,
   input  wire logic                 reset,
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   output nvm_ctrl_pkg::memCmd_t     memCmd,
   input  wire logic [13:0]          memReadData,
   input  wire logic                 memDone,
   input  wire logic                 codeProtect,
   input  wire logic [10:0]          writeProtLimit,
   output logic                      cpuStall,
   output logic                      doneIrq
);

   typedef struct packed {
      logic                       awHave;
      logic [ADDR_W-1:0]          awAddr;
      logic                       wHave;
      logic [7:0]                 wData;
      logic                       wLane;
      logic                       bValid;
      logic [1:0]                 bResp;
      logic                       rValid;
      logic [31:0]                rData;
      logic [1:0]                 rResp;
      logic [7:0]                 control;
      logic [7:0]                 addrLow;
      logic [7:0]                 addrHigh;
      logic [7:0]                 dataLow;
      logic [5:0]                 dataHigh;
      logic                       doneFlag;
      logic                       irqEnable;
      nvm_ctrl_pkg::unlockState_t unlock;
      nvm_ctrl_pkg::seqState_t    seq;
      nvm_ctrl_pkg::memOp_t       curOp;
      nvm_ctrl_pkg::memCmd_t      cmd;
   } state_t;

   state_t state;
   state_t next_state;

   // Classify a word address against the selected region
   function automatic nvm_ctrl_pkg::addrClass_t classify(input logic        region,
                                                         input logic [15:0] addr);
      nvm_ctrl_pkg::addrClass_t cls;
      // Holes such as 8004h decode as no target
      cls = nvm_ctrl_pkg::CLS_NONE;
      if (!region) begin
         if (addr >= nvm_ctrl_pkg::PFM_BASE && addr <= nvm_ctrl_pkg::PFM_LAST) begin
            cls = nvm_ctrl_pkg::CLS_PFM;
         end
      end else if (addr >= nvm_ctrl_pkg::UID_BASE && addr <= nvm_ctrl_pkg::UID_LAST) begin
         cls = nvm_ctrl_pkg::CLS_UID;
      end else if (addr >= nvm_ctrl_pkg::RO_BASE && addr <= nvm_ctrl_pkg::RO_LAST) begin
         cls = nvm_ctrl_pkg::CLS_RO;
      end else if (addr >= nvm_ctrl_pkg::EE_BASE && addr <= nvm_ctrl_pkg::EE_LAST) begin
         cls = nvm_ctrl_pkg::CLS_EE;
      end
      return cls;
   endfunction : classify

   // Offsets that answer OKAY; anything else gets SLVERR
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      return a == nvm_ctrl_pkg::OFS_CONTROL   || a == nvm_ctrl_pkg::OFS_UNLOCK
          || a == nvm_ctrl_pkg::OFS_ADDR_LOW  || a == nvm_ctrl_pkg::OFS_ADDR_HIGH
          || a == nvm_ctrl_pkg::OFS_DATA_LOW  || a == nvm_ctrl_pkg::OFS_DATA_HIGH
          || a == nvm_ctrl_pkg::OFS_STATUS;
   endfunction : mapped

   logic [15:0]              curAddr;
   logic                     region;
   nvm_ctrl_pkg::addrClass_t curClass;
   logic                     pfmProtected;
   logic                     doWrite;
   logic                     doRead;
   logic [7:0]               wByte;
   logic                     startReq;
   logic                     busy;
   logic                     keyPeek;

   assign curAddr      = {state.addrHigh, state.addrLow};
   assign region       = state.control[nvm_ctrl_pkg::CTL_CONFIG_SPACE];
   assign curClass     = classify(region, curAddr);
   // Lower part of flash below the limit is protected from self-write
   assign pfmProtected = (curClass == nvm_ctrl_pkg::CLS_PFM) && (curAddr[10:0] < writeProtLimit);
   assign doWrite      = state.awHave && state.wHave && !state.bValid;
   assign doRead       = s_axi_arvalid && !state.rValid;
   assign wByte        = state.wData;
   assign busy         = state.seq != nvm_ctrl_pkg::SEQ_IDLE;
   assign startReq     = doWrite && state.wLane && state.awAddr == nvm_ctrl_pkg::OFS_CONTROL
                         && wByte[nvm_ctrl_pkg::CTL_WRITE_START];
   // Key read racing a key write still breaks unlock
   assign keyPeek      = doRead && s_axi_araddr == nvm_ctrl_pkg::OFS_UNLOCK;

   // Next-state logic: bus slave, unlock checker and operation sequencer
   always_comb begin
      next_state           = state;
      next_state.cmd.valid = 1'b0;

      // Address and data channels are taken independently, in either order
      if (s_axi_awvalid && !state.awHave) begin
         next_state.awHave = 1'b1;
         next_state.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !state.wHave) begin
         next_state.wHave = 1'b1;
         next_state.wData = s_axi_wdata[7:0];
         next_state.wLane = s_axi_wstrb[0];
      end
      // Responses stand until taken
      if (state.bValid && s_axi_bready) begin
         next_state.bValid = 1'b0;
      end
      if (state.rValid && s_axi_rready) begin
         next_state.rValid = 1'b0;
      end

      // Completion of a running operation
      if (state.seq == nvm_ctrl_pkg::SEQ_READ) begin
         // Sampled in the stall cycle; no memDone
         next_state.dataLow  = memReadData[7:0];
         next_state.dataHigh = memReadData[13:8];
         next_state.control[nvm_ctrl_pkg::CTL_READ_START] = 1'b0;
         next_state.seq = nvm_ctrl_pkg::SEQ_IDLE;
      end else if (busy && memDone) begin
         next_state.control[nvm_ctrl_pkg::CTL_WRITE_START] = 1'b0;
         next_state.seq = nvm_ctrl_pkg::SEQ_IDLE;
      end

      // Register read; a key register read breaks the unlock sequence
      if (doRead) begin
         next_state.rValid = 1'b1;
         next_state.rResp  = mapped(s_axi_araddr) ? nvm_ctrl_pkg::RESP_OKAY
                                                  : nvm_ctrl_pkg::RESP_SLVERR;
         next_state.rData  = 32'h0000_0000;
         case (s_axi_araddr)
            nvm_ctrl_pkg::OFS_CONTROL:   next_state.rData[7:0] = state.control;
            nvm_ctrl_pkg::OFS_UNLOCK:    next_state.unlock = nvm_ctrl_pkg::UL_IDLE;
            nvm_ctrl_pkg::OFS_ADDR_LOW:  next_state.rData[7:0] = state.addrLow;
            nvm_ctrl_pkg::OFS_ADDR_HIGH: next_state.rData[7:0] = state.addrHigh;
            nvm_ctrl_pkg::OFS_DATA_LOW:  next_state.rData[7:0] = state.dataLow;
            nvm_ctrl_pkg::OFS_DATA_HIGH: next_state.rData[5:0] = state.dataHigh;
            nvm_ctrl_pkg::OFS_STATUS: begin
               next_state.rData[nvm_ctrl_pkg::STS_DONE_FLAG]  = state.doneFlag;
               next_state.rData[nvm_ctrl_pkg::STS_IRQ_ENABLE] = state.irqEnable;
               next_state.rData[nvm_ctrl_pkg::STS_BUSY]       = busy;
            end
            default: next_state.rData = 32'h0000_0000;
         endcase
      end

      // Register write, once both halves have arrived
      if (doWrite) begin
         next_state.awHave = 1'b0;
         next_state.wHave  = 1'b0;
         next_state.bValid = 1'b1;
         next_state.bResp  = mapped(state.awAddr) ? nvm_ctrl_pkg::RESP_OKAY
                                                  : nvm_ctrl_pkg::RESP_SLVERR;
         // Any write that is not the expected next step drops the unlock
         next_state.unlock = nvm_ctrl_pkg::UL_IDLE;
         // Lane 0 off: answered, nothing stored
         if (state.wLane) begin
            case (state.awAddr)
               nvm_ctrl_pkg::OFS_UNLOCK: begin
                  if (state.unlock == nvm_ctrl_pkg::UL_IDLE
                      && wByte == nvm_ctrl_pkg::UNLOCK_KEY_FIRST) begin
                     next_state.unlock = nvm_ctrl_pkg::UL_KEY1;
                  end else if (state.unlock == nvm_ctrl_pkg::UL_KEY1
                               && wByte == nvm_ctrl_pkg::UNLOCK_KEY_SECOND) begin
                     next_state.unlock = nvm_ctrl_pkg::UL_KEY2;
                  end
               end
               nvm_ctrl_pkg::OFS_CONTROL: begin
                  // Mode bits may be changed any time; start bits are hardware owned
                  next_state.control[nvm_ctrl_pkg::CTL_WRITE_ENABLE] =
                     wByte[nvm_ctrl_pkg::CTL_WRITE_ENABLE];
                  next_state.control[nvm_ctrl_pkg::CTL_ROW_ERASE] =
                     wByte[nvm_ctrl_pkg::CTL_ROW_ERASE];
                  next_state.control[nvm_ctrl_pkg::CTL_LATCH_ONLY] =
                     wByte[nvm_ctrl_pkg::CTL_LATCH_ONLY];
                  next_state.control[nvm_ctrl_pkg::CTL_CONFIG_SPACE] =
                     wByte[nvm_ctrl_pkg::CTL_CONFIG_SPACE];
               end
               nvm_ctrl_pkg::OFS_ADDR_LOW:  next_state.addrLow  = wByte;
               nvm_ctrl_pkg::OFS_ADDR_HIGH: next_state.addrHigh = wByte;
               nvm_ctrl_pkg::OFS_DATA_LOW:  next_state.dataLow  = wByte;
               nvm_ctrl_pkg::OFS_DATA_HIGH: next_state.dataHigh = wByte[5:0];
               nvm_ctrl_pkg::OFS_STATUS: begin
                  // Write-one clear; a same-cycle set wins
                  next_state.irqEnable = wByte[nvm_ctrl_pkg::STS_IRQ_ENABLE];
                  if (wByte[nvm_ctrl_pkg::STS_DONE_FLAG]) begin
                     next_state.doneFlag = 1'b0;
                  end
               end
               default: next_state.unlock = nvm_ctrl_pkg::UL_IDLE;
            endcase
         end
      end

      // Read start: refused under code protection or while busy
      if (doWrite && state.wLane && state.awAddr == nvm_ctrl_pkg::OFS_CONTROL
          && wByte[nvm_ctrl_pkg::CTL_READ_START] && !busy && !startReq) begin
         if (!codeProtect && curClass != nvm_ctrl_pkg::CLS_NONE) begin
            // Visible only in its one stall cycle
            next_state.control[nvm_ctrl_pkg::CTL_READ_START] = 1'b1;
            next_state.seq        = nvm_ctrl_pkg::SEQ_READ;
            next_state.cmd.valid  = 1'b1;
            next_state.cmd.op     = nvm_ctrl_pkg::MEM_READ;
            next_state.cmd.region = region;
            next_state.cmd.addr   = curAddr;
            next_state.cmd.data   = 14'h0000;
         end
      end

      // Write start: only straight after both keys, with writes enabled
      if (startReq && state.unlock == nvm_ctrl_pkg::UL_KEY2 && !busy
          && wByte[nvm_ctrl_pkg::CTL_WRITE_ENABLE] && !codeProtect) begin
         // Pointer and data go out with every command
         next_state.cmd.region = region;
         next_state.cmd.addr   = curAddr;
         next_state.cmd.data   = {state.dataHigh, state.dataLow};
         if (curClass == nvm_ctrl_pkg::CLS_EE) begin
            // Word write carries its own erase, row erase bit not consulted
            next_state.cmd.valid = 1'b1;
            next_state.cmd.op    = nvm_ctrl_pkg::MEM_EE_WRITE;
            next_state.seq       = nvm_ctrl_pkg::SEQ_BACKGROUND;
         end else if (curClass == nvm_ctrl_pkg::CLS_PFM || curClass == nvm_ctrl_pkg::CLS_UID) begin
            if (wByte[nvm_ctrl_pkg::CTL_ROW_ERASE]) begin
               // Erase touches neither latches nor write enable
               next_state.cmd.valid = !pfmProtected;
               next_state.cmd.op    = nvm_ctrl_pkg::MEM_ROW_ERASE;
            end else if (wByte[nvm_ctrl_pkg::CTL_LATCH_ONLY]) begin
               next_state.cmd.valid = 1'b1;
               next_state.cmd.op    = nvm_ctrl_pkg::MEM_LATCH;
            end else begin
               // Plain program, no erase issued ahead of it
               next_state.cmd.valid = !pfmProtected;
               next_state.cmd.op    = nvm_ctrl_pkg::MEM_ROW_WRITE;
            end
            // Only an issued command stalls
            if (next_state.cmd.valid) begin
               next_state.seq = nvm_ctrl_pkg::SEQ_FOREGROUND;
            end
         end
         // Op kept so completion knows to flag
         if (next_state.cmd.valid) begin
            next_state.curOp = next_state.cmd.op;
            next_state.control[nvm_ctrl_pkg::CTL_WRITE_START] = 1'b1;
         end else begin
            next_state.control[nvm_ctrl_pkg::CTL_WRITE_START] = 1'b0;
         end
      end

      // Done flag set after the clear so a completing event always wins
      if (busy && state.seq != nvm_ctrl_pkg::SEQ_READ && memDone
          && state.curOp != nvm_ctrl_pkg::MEM_LATCH) begin
         next_state.doneFlag = 1'b1;
      end

      // Start bit stays set by hardware; a clear by software is ignored
      if (busy && state.seq != nvm_ctrl_pkg::SEQ_READ && !memDone) begin
         next_state.control[nvm_ctrl_pkg::CTL_WRITE_START] = 1'b1;
      end

      // Key register read overrides any step
      if (keyPeek) begin
         next_state.unlock = nvm_ctrl_pkg::UL_IDLE;
      end
   end

   // Single state register
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         // One-hot enums get legal codes, not all zeros
         state         <= '0;
         state.control <= nvm_ctrl_pkg::CONTROL_RESET;
         state.unlock  <= nvm_ctrl_pkg::UL_IDLE;
         state.seq     <= nvm_ctrl_pkg::SEQ_IDLE;
         state.curOp   <= nvm_ctrl_pkg::MEM_NONE;
      end else begin
         state <= next_state;
      end
   end

   // Bus handshakes, data and responses all come from flops, none from inputs
   assign s_axi_awready = !state.awHave;
   assign s_axi_wready  = !state.wHave;
   assign s_axi_bvalid  = state.bValid;
   assign s_axi_bresp   = state.bResp;
   assign s_axi_arready = !state.rValid;
   assign s_axi_rvalid  = state.rValid;
   assign s_axi_rdata   = state.rData;
   assign s_axi_rresp   = state.rResp;
   assign memCmd        = state.cmd;

   // Stall covers reads and foreground ops; the cycle after release runs normally
   assign cpuStall = state.seq == nvm_ctrl_pkg::SEQ_READ
                  || state.seq == nvm_ctrl_pkg::SEQ_FOREGROUND;
   assign doneIrq  = state.doneFlag && state.irqEnable;

endmodule : nvm_unlock_erase_write_ctrl

/* File: nvm_unlock_erase_write_ctrl_properties.sv */
`timescale 1ns/10ps

module nvm_unlock_erase_write_ctrl_properties #(
   parameter int ADDR_W = 5
) (
   input wire logic                  core_clk,
   input wire logic                  reset,
   input wire logic                  s_axi_bvalid,
   input wire nvm_ctrl_pkg::memCmd_t memCmd,
   input wire logic                  memDone,
   input wire logic                  codeProtect,
   input wire logic [10:0]           writeProtLimit,
   input wire logic                  cpuStall
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   // Command classes seen on the array side
   sequence fgCmd;
      memCmd.valid && memCmd.op inside {nvm_ctrl_pkg::MEM_LATCH, nvm_ctrl_pkg::MEM_ROW_WRITE,
                                        nvm_ctrl_pkg::MEM_ROW_ERASE};
   endsequence
   sequence readCmd;
      memCmd.valid && memCmd.op == nvm_ctrl_pkg::MEM_READ;
   endsequence
   sequence eeCmd;
      memCmd.valid && memCmd.op == nvm_ctrl_pkg::MEM_EE_WRITE;
   endsequence

   a_cmd_one_cycle: assert property (memCmd.valid |=> !memCmd.valid)
      else $error("memCmd valid held longer than one cycle");
   a_cmd_after_write: assert property (memCmd.valid |-> $rose(s_axi_bvalid))
      else $error("memCmd issued without a completing register write");
   a_cmd_not_protected: assert property (memCmd.valid |-> !codeProtect)
      else $error("memCmd issued while code protected");
   a_fg_stalls: assert property (fgCmd |-> cpuStall)
      else $error("foreground op without cpu stall");
   a_stall_release: assert property (cpuStall && memDone |=> !cpuStall)
      else $error("cpu stall not released after memDone");
   a_read_stall: assert property (readCmd |-> cpuStall ##1 !cpuStall)
      else $error("read stall not exactly one cycle");
   a_ee_background: assert property (eeCmd |-> !cpuStall && memCmd.region &&
      memCmd.addr >= nvm_ctrl_pkg::EE_BASE && memCmd.addr <= nvm_ctrl_pkg::EE_LAST)
      else $error("eeprom write stalls or decodes wrongly");
   a_wp_respected: assert property (memCmd.valid && !memCmd.region && memCmd.op inside
      {nvm_ctrl_pkg::MEM_ROW_ERASE, nvm_ctrl_pkg::MEM_ROW_WRITE}
      |-> memCmd.addr[10:0] >= writeProtLimit)
      else $error("protected flash row erased or written");
endmodule : nvm_unlock_erase_write_ctrl_properties

/* File: nvm_unlock_erase_write_ctrl_test.sv */
`timescale 1ns/10ps

module nvm_unlock_erase_write_ctrl_test;
   logic                  core_clk = 1'b0;
   logic                  reset = 1'b1;
   logic [4:0]            awaddr = 5'h00, araddr = 5'h00;
   logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                  arvalid = 1'b0, rready = 1'b0, memDone = 1'b0;
   logic [31:0]           wdata = 32'h0;
   logic                  awready, wready, bvalid, arready, rvalid, cpuStall, doneIrq;
   logic [1:0]            bresp, rresp;
   logic [31:0]           rdata;
   nvm_ctrl_pkg::memCmd_t memCmd, lastCmd;
   logic [13:0]           memReadData = 14'h0;
   logic                  codeProtect = 1'b0;
   logic [10:0]           writeProtLimit = 11'h020;
   int                    miscompares = 0, nTests = 0, cmdCount = 0, c0;
   logic [31:0]           d;
   logic [1:0]            r;

   always #50 core_clk = ~core_clk;

   nvm_unlock_erase_write_ctrl u_nvm_unlock_erase_write_ctrl (.core_clk(core_clk),
      .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .memCmd(memCmd),
      .memReadData(memReadData), .memDone(memDone), .codeProtect(codeProtect),
      .writeProtLimit(writeProtLimit), .cpuStall(cpuStall), .doneIrq(doneIrq));

   // Array side monitor keeps the last command issued
   always @(posedge core_clk) if (memCmd.valid === 1'b1) begin
      cmdCount++;
      lastCmd = memCmd;
   end

   task automatic summarize;
      $display("tests %0d mismatches %0d", nTests, miscompares);
      if (miscompares == 0 && nTests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : summarize

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : check

   // Bounded wait ran out: count it and close the run
   task automatic hang;
      miscompares++;
      $display("[ERR] handshake expected answer seen none");
      summarize();
   endtask : hang

   task automatic axiWrite(input logic [4:0] a, input logic [31:0] v);
      int n;
      @(posedge core_clk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 50) hang();
      r = bresp;
      bready <= 1'b0;
   endtask : axiWrite

   task automatic axiRead(input logic [4:0] a);
      int n;
      @(posedge core_clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 50) hang();
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axiRead

   task automatic settle;
      @(posedge core_clk);
      #1;
   endtask : settle

   task automatic pulseDone;
      @(posedge core_clk) memDone <= 1'b1;
      @(posedge core_clk) memDone <= 1'b0;
      settle();
   endtask : pulseDone

   // Address, mode bits, both keys, then the start write
   task automatic startOp(input logic [15:0] a, input logic [7:0] ctl);
      axiWrite(nvm_ctrl_pkg::OFS_ADDR_LOW, {24'h0, a[7:0]});
      axiWrite(nvm_ctrl_pkg::OFS_ADDR_HIGH, {24'h0, a[15:8]});
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, {24'h0, ctl & 8'hFD});
      c0 = cmdCount;
      axiWrite(nvm_ctrl_pkg::OFS_UNLOCK, 32'h55);
      axiWrite(nvm_ctrl_pkg::OFS_UNLOCK, 32'hAA);
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, {24'h0, ctl});
      settle();
   endtask : startOp

   task automatic tErase;
      axiWrite(nvm_ctrl_pkg::OFS_STATUS, 32'h2);
      startOp(16'h8040, 8'h0E);
      check("erase count", c0 + 1, cmdCount);
      check("erase op", nvm_ctrl_pkg::MEM_ROW_ERASE, lastCmd.op);
      check("erase stall", 1, cpuStall);
      axiRead(nvm_ctrl_pkg::OFS_CONTROL);
      check("start bit busy", 32'h0E, d);
      pulseDone();
      check("stall after done", 0, cpuStall);
      check("done irq", 1, doneIrq);
      axiRead(nvm_ctrl_pkg::OFS_STATUS);
      check("erase status", 32'h3, d);
      axiRead(nvm_ctrl_pkg::OFS_CONTROL);
      check("erase keeps enable", 32'h0C, d);
      axiWrite(nvm_ctrl_pkg::OFS_STATUS, 32'h3);
      $display("erase test done");
   endtask : tErase

   task automatic tRefused;
      logic [7:0] k1[3] = '{8'hAA, 8'h55, 8'h55};
      logic [7:0] k2[3] = '{8'h55, 8'h55, 8'hAA};
      startOp(16'h8010, 8'h0E);
      check("protected erase", c0, cmdCount);
      axiRead(nvm_ctrl_pkg::OFS_CONTROL);
      check("protected start bit", 32'h0C, d);
      startOp(16'h8040, 8'h0A);
      check("start without enable", c0, cmdCount);
      for (int i = 0; i < 3; i++) begin
         axiWrite(nvm_ctrl_pkg::OFS_UNLOCK, {24'h0, k1[i]});
         if (i == 2) axiWrite(nvm_ctrl_pkg::OFS_ADDR_LOW, 32'h40);
         axiWrite(nvm_ctrl_pkg::OFS_UNLOCK, {24'h0, k2[i]});
         axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h0E);
         settle();
         check("bad key order", c0, cmdCount);
      end
      @(posedge core_clk) codeProtect <= 1'b1;
      startOp(16'h8040, 8'h0E);
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h01);
      settle();
      check("code protected", c0, cmdCount);
      @(posedge core_clk) codeProtect <= 1'b0;
      axiWrite(5'h1C, 32'h1);
      check("unmapped resp", nvm_ctrl_pkg::RESP_SLVERR, r);
      axiRead(5'h1C);
      check("unmapped rresp", nvm_ctrl_pkg::RESP_SLVERR, r);
      $display("refusal test done");
   endtask : tRefused

   task automatic tLatch;
      startOp(16'h8041, 8'h16);
      check("latch op", nvm_ctrl_pkg::MEM_LATCH, lastCmd.op);
      pulseDone();
      axiRead(nvm_ctrl_pkg::OFS_STATUS);
      check("latch no flag", 32'h2, d);
      startOp(16'h8041, 8'h06);
      check("row write op", nvm_ctrl_pkg::MEM_ROW_WRITE, lastCmd.op);
      pulseDone();
      axiRead(nvm_ctrl_pkg::OFS_STATUS);
      check("row write flag", 32'h3, d);
      axiWrite(nvm_ctrl_pkg::OFS_STATUS, 32'h3);
      $display("latch test done");
   endtask : tLatch

   task automatic tEeprom;
      axiWrite(nvm_ctrl_pkg::OFS_DATA_LOW, 32'h5A);
      axiWrite(nvm_ctrl_pkg::OFS_DATA_HIGH, 32'h0);
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h44);
      startOp(16'hF005, 8'h46);
      check("ee op", nvm_ctrl_pkg::MEM_EE_WRITE, lastCmd.op);
      check("ee addr", 16'hF005, lastCmd.addr);
      check("ee data", 14'h005A, lastCmd.data);
      check("ee no stall", 0, cpuStall);
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h44);
      axiRead(nvm_ctrl_pkg::OFS_CONTROL);
      check("ee clear ignored", 32'h46, d);
      pulseDone();
      axiRead(nvm_ctrl_pkg::OFS_CONTROL);
      check("ee start cleared", 32'h44, d);
      check("ee irq", 1, doneIrq);
      $display("eeprom test done");
   endtask : tEeprom

   task automatic tRead;
      memReadData <= 14'h2ABC;
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h00);
      axiWrite(nvm_ctrl_pkg::OFS_ADDR_LOW, 32'h00);
      axiWrite(nvm_ctrl_pkg::OFS_ADDR_HIGH, 32'h81);
      c0 = cmdCount;
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h01);
      settle();
      check("read op", nvm_ctrl_pkg::MEM_READ, lastCmd.op);
      axiRead(nvm_ctrl_pkg::OFS_DATA_LOW);
      check("read low", 32'hBC, d);
      axiRead(nvm_ctrl_pkg::OFS_DATA_HIGH);
      check("read high", 32'h2A, d);
      axiRead(nvm_ctrl_pkg::OFS_CONTROL);
      check("read start cleared", 32'h00, d);
      startOp(16'h8006, 8'h46);
      check("ro write refused", c0, cmdCount);
      axiWrite(nvm_ctrl_pkg::OFS_CONTROL, 32'h41);
      settle();
      check("ro read addr", 16'h8006, lastCmd.addr);
      $display("read test done");
   endtask : tRead

   initial begin
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      tErase();
      tRefused();
      tLatch();
      tEeprom();
      tRead();
      summarize();
   end
endmodule : nvm_unlock_erase_write_ctrl_test

bind nvm_unlock_erase_write_ctrl nvm_unlock_erase_write_ctrl_properties #(.ADDR_W(ADDR_W))
   u_nvm_unlock_erase_write_ctrl_properties (.core_clk(core_clk), .reset(reset),
   .s_axi_bvalid(s_axi_bvalid), .memCmd(memCmd), .memDone(memDone),
   .codeProtect(codeProtect), .writeProtLimit(writeProtLimit), .cpuStall(cpuStall));
